/* File: bscan_lower.sv */
// lower boundary chain (cells 81..0), test port disable and reset source register
`timescale 1ns/1ps
`default_nettype none
`include "bscan_map.svh"
module bscan_lower
  import bscan_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  input  wire logic                 TCK,
  input  wire logic                 TDI,
  input  wire logic                 TAP_CAPTURE,
  input  wire logic                 TAP_SHIFT,
  input  wire logic                 TAP_UPDATE,
  input  wire logic                 TAP_EXTEST,
  input  wire logic                 TEST_RESET_REQ,
  input  wire logic                 TEST_PORT_FUSE,
  input  wire logic                 EXT_RST_EVT,
  input  wire logic                 BOD_RST_EVT,
  input  wire logic                 WDT_RST_EVT,
  input  wire logic                 RESET_PIN_LVL,
  input  wire logic                 RESET_HV_DET,
  input  wire logic [3:0]           CLK_OBS,
  input  wire logic                 TIMER_OSC_CELL_OBS,
  input  wire logic [`NUM_PINS-1:0] PIN_IN,
  input  wire logic [`NUM_PINS-1:0] CORE_VAL,
  input  wire logic [`NUM_PINS-1:0] CORE_DIR,
  input  wire logic [`NUM_PINS-1:0] CORE_PULL,
  input  wire logic [3:0]           CORE_OSC_EN,
  input  wire logic                 CORE_TWI_EN,
  input  wire logic                 CORE_TIMER_OSC_CELL_EN,
  output logic      [`NUM_PINS-1:0] PIN_OUT,
  output logic      [`NUM_PINS-1:0] PIN_OE_N,
  output logic      [`NUM_PINS-1:0] PIN_PULL,
  output logic      [3:0]           OSC_EN,
  output logic                      TWI_EN,
  output logic                      TIMER_OSC_CELL_EN,
  output logic                      TDO,
  output logic                      TEST_PORT_EN,
  output logic                      IRQ
);
  // ---------------------------------------------------------------
  // chain position of a pin's lowest cell (pull-up)
  // ---------------------------------------------------------------
  function automatic int pin_base(input int p);
    if (p < `SEG_A_PINS) begin
      pin_base = 3 * p;
    end else if (p < `SEG_A_PINS + `SEG_CD_PINS) begin
      pin_base = `SEG_CD_BASE + 3 * (p - `SEG_A_PINS);
    end else begin
      pin_base = `SEG_B_BASE + 3 * (p - `SEG_A_PINS - `SEG_CD_PINS);
    end
  endfunction : pin_base

  // ---------------------------------------------------------------
  // synchronisers for everything from outside this clock
  // ---------------------------------------------------------------
  logic [17:0]          ctl_s;
  logic [`NUM_PINS-1:0] pin_s;

  bscan_sync #(.W(18)) u_ctl_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     ({TCK, TDI, TAP_CAPTURE, TAP_SHIFT, TAP_UPDATE, TAP_EXTEST,
             TEST_RESET_REQ, TEST_PORT_FUSE, EXT_RST_EVT, BOD_RST_EVT,
             WDT_RST_EVT, RESET_PIN_LVL, RESET_HV_DET, CLK_OBS, TIMER_OSC_CELL_OBS}),
    .q     (ctl_s)
  );

  bscan_sync #(.W(`NUM_PINS)) u_pin_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     (PIN_IN),
    .q     (pin_s)
  );

  logic       tck_s;
  logic       tdi_s;
  logic       cap_s;
  logic       sh_s;
  logic       upd_s;
  logic       ext_s;
  logic       trst_s;
  logic       fuse_s;
  logic [2:0] rst_evt_s;
  logic       rst_lvl_s;
  logic       rst_hv_s;
  logic [3:0] clk_obs_s;
  logic       timer_osc_cell_s;

  assign {tck_s, tdi_s, cap_s, sh_s, upd_s, ext_s, trst_s, fuse_s, rst_evt_s,
          rst_lvl_s, rst_hv_s, clk_obs_s, timer_osc_cell_s} = ctl_s;

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  top_state_t s_r;
  top_state_t s_nxt;

  logic tck_rise;
  logic tck_fall;
  logic extest;
  logic addr_ok;
  logic csr_wr;
  logic st_wr;
  logic mask_wr;

  assign tck_rise = s_r.port_en & tck_s & ~s_r.tck_q;
  assign tck_fall = s_r.port_en & ~tck_s & s_r.tck_q;
  assign extest   = s_r.port_en & ext_s;
  assign addr_ok  = HSEL & HTRANS[1] & HREADY;
  assign csr_wr   = s_r.dp_wr && (s_r.dp_idx == `CSR_IDX);
  assign st_wr    = s_r.dp_wr && (s_r.dp_idx == `IRQ_ST_IDX);
  assign mask_wr  = s_r.dp_wr && (s_r.dp_idx == `IRQ_MASK_IDX);

  logic [7:0] csr_view;

  assign csr_view = {s_r.dis, 2'h0, s_r.flags};

  always_comb begin
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [3:0] ev;
    logic [3:0] ev_clr;
    s_nxt        = s_r;
    flag_set     = 5'h00;
    flag_clr     = 5'h00;
    ev           = 4'h0;
    ev_clr       = 4'h0;
    s_nxt.tck_q  = tck_s;
    s_nxt.hready = 1'b1;
    s_nxt.hresp  = 1'b0;

    // -------------------------------------------------------------
    // chain: capture and shift on rising, output and update on falling
    // -------------------------------------------------------------
    if (tck_rise && cap_s) begin
      for (int p = 0; p < `NUM_PINS; p++) begin
        s_nxt.chain[pin_base(p) + 2] = pin_s[p];
        s_nxt.chain[pin_base(p) + 1] = CORE_DIR[p];
        s_nxt.chain[pin_base(p)]     = CORE_PULL[p];
      end
      s_nxt.chain[`CH_RST_LVL]                 = rst_lvl_s;
      s_nxt.chain[`CH_RST_HV]                  = rst_hv_s;
      s_nxt.chain[`CH_OSCEN_HI:`CH_OSCEN_LO]   = s_r.osc_en;
      s_nxt.chain[`CH_OSCOBS_HI:`CH_OSCOBS_LO] = clk_obs_s;
      s_nxt.chain[`CH_TWI_EN]                  = s_r.twi_en;
      s_nxt.chain[`CH_TIMER_OSC_CELL]                    = timer_osc_cell_s;
      s_nxt.chain[`CH_TIMER_OSC_CELL_EN]                 = s_r.timer_osc_cell_en;
      ev[`IRQ_CAP_BIT]                         = 1'b1;
    end else if (tck_rise && sh_s) begin
      s_nxt.chain = {tdi_s, s_r.chain[`CHAIN_LEN-1:1]};
    end
    if (tck_fall) begin
      s_nxt.tdo = s_r.chain[0];
      if (upd_s) begin
        s_nxt.upd          = s_r.chain;
        ev[`IRQ_UPD_BIT]   = 1'b1;
      end
    end
    if (!s_r.port_en) begin
      s_nxt.tdo = 1'b0;
    end

    // -------------------------------------------------------------
    // functional or test drive of the non-pin cells
    // -------------------------------------------------------------
    if (extest) begin
      s_nxt.osc_en  = s_r.upd[`CH_OSCEN_HI:`CH_OSCEN_LO];
      s_nxt.twi_en  = s_r.upd[`CH_TWI_EN];
      s_nxt.timer_osc_cell_en = s_r.upd[`CH_TIMER_OSC_CELL_EN];
    end else begin
      s_nxt.osc_en  = CORE_OSC_EN;
      s_nxt.twi_en  = CORE_TWI_EN;
      s_nxt.timer_osc_cell_en = CORE_TIMER_OSC_CELL_EN;
    end

    // -------------------------------------------------------------
    // test port disable with timed write
    // -------------------------------------------------------------
    s_nxt.port_en = fuse_s & ~s_r.dis;
    s_nxt.tw_cnt  = (s_r.tw_cnt != 3'h0) ? 3'(s_r.tw_cnt - 3'h1) : 3'h0;
    if (csr_wr) begin
      if ((s_r.tw_cnt != 3'h0) && (s_r.tw_val == HWDATA[`CSR_DIS_BIT])) begin
        s_nxt.dis    = s_r.tw_val;
        s_nxt.tw_cnt = 3'h0;
        if (s_r.dis != s_r.tw_val) begin
          ev[`IRQ_DIS_BIT] = 1'b1;
        end
      end else begin
        s_nxt.tw_val = HWDATA[`CSR_DIS_BIT];
        s_nxt.tw_cnt = `TW_CYCLES;
      end
      flag_clr = ~HWDATA[4:0];
    end

    // -------------------------------------------------------------
    // reset source flags, set wins over clear
    // -------------------------------------------------------------
    flag_set[`CSR_EXT_BIT]  = rst_evt_s[2];
    flag_set[`CSR_BOD_BIT]  = rst_evt_s[1];
    flag_set[`CSR_WDT_BIT]  = rst_evt_s[0];
    flag_set[`CSR_TEST_RESET_FLAG_BIT] = trst_s;
    s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;
    if (trst_s && !s_r.flags[`CSR_TEST_RESET_FLAG_BIT]) begin
      ev[`IRQ_TRST_BIT] = 1'b1;
    end

    // -------------------------------------------------------------
    // interrupts: sticky, write one to clear, masked level out
    // -------------------------------------------------------------
    if (st_wr) begin
      ev_clr = HWDATA[3:0];
    end
    if (mask_wr) begin
      s_nxt.irq_mask = HWDATA[3:0];
    end
    s_nxt.irq_st = (s_r.irq_st & ~ev_clr) | ev;
    s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_mask);

    // -------------------------------------------------------------
    // bus: address phase capture, read data ready for data phase
    // -------------------------------------------------------------
    s_nxt.dp_wr  = addr_ok & HWRITE;
    s_nxt.dp_idx = HADDR[7:2];
    s_nxt.rdata  = 32'h0000_0000;
    if (addr_ok && !HWRITE) begin
      case (HADDR[7:2])
        `CSR_IDX:      s_nxt.rdata = {24'h00_0000, csr_view};
        `IRQ_ST_IDX:   s_nxt.rdata = {28'h000_0000, s_r.irq_st};
        `IRQ_MASK_IDX: s_nxt.rdata = {28'h000_0000, s_r.irq_mask};
        default:       s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // power-on reset: the only reset that clears the test reset flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_r        <= '0;
      s_r.flags  <= `FLAGS_RESET;
      s_r.hready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pin cells
  // ---------------------------------------------------------------
  for (genvar p = 0; p < `NUM_PINS; p++) begin : g_pin
    localparam int B = pin_base(p);
    bscan_pin_cell u_cell (
      .clk       (CLK),
      .reset     (RESET),
      .extest    (extest),
      .upd       (s_r.upd[B+2:B]),
      .core_val  (CORE_VAL[p]),
      .core_dir  (CORE_DIR[p]),
      .core_pull (CORE_PULL[p]),
      .pin_out   (PIN_OUT[p]),
      .pin_oe_n  (PIN_OE_N[p]),
      .pin_pull  (PIN_PULL[p])
    );
  end

  assign HRDATA       = s_r.rdata;
  assign HREADYOUT    = s_r.hready;
  assign HRESP        = s_r.hresp;
  assign OSC_EN       = s_r.osc_en;
  assign TWI_EN       = s_r.twi_en;
  assign TIMER_OSC_CELL_EN      = s_r.timer_osc_cell_en;
  assign TDO          = s_r.tdo;
  assign TEST_PORT_EN = s_r.port_en;
  assign IRQ          = s_r.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  dis_timed_a: assert property ($changed(s_r.dis) |->
      $past(csr_wr) && ($past(s_r.tw_cnt) != 3'h0))
    else $error("disable bit changed without a timed second write");

  port_en_a: assert property (##1 TEST_PORT_EN ==
      ($past(fuse_s) && !$past(s_r.dis)))
    else $error("test port enable does not follow fuse and disable bit");

  test_reset_flag_set_a: assert property (trst_s |=> s_r.flags[`CSR_TEST_RESET_FLAG_BIT])
    else $error("test reset did not set its flag");

  test_reset_flag_clear_a: assert property ($fell(s_r.flags[`CSR_TEST_RESET_FLAG_BIT]) |->
      $past(csr_wr) && !$past(HWDATA[`CSR_TEST_RESET_FLAG_BIT]))
    else $error("test reset flag cleared without a zero write");

  shift_order_a: assert property ((tck_rise && !cap_s && sh_s) |=>
      s_r.chain == {$past(tdi_s), $past(s_r.chain[`CHAIN_LEN-1:1])})
    else $error("chain did not shift toward cell zero");

  osc_obs_a: assert property ((tck_rise && cap_s) |=>
      s_r.chain[`CH_OSCOBS_HI:`CH_OSCOBS_LO] == $past(clk_obs_s))
    else $error("clock observe cells captured wrong values");

  osc_drive_a: assert property (extest |=>
      OSC_EN == $past(s_r.upd[`CH_OSCEN_HI:`CH_OSCEN_LO]))
    else $error("clock enables do not follow their update cells");

  rst_obs_a: assert property ((tck_rise && cap_s) |=>
      s_r.chain[`CH_RST_LVL:`CH_RST_HV] == $past({rst_lvl_s, rst_hv_s}))
    else $error("reset observe cells captured wrong values");
endmodule : bscan_lower
`default_nettype wire

/* File: bscan_map.svh */
// offsets, field positions, reset values and counts of the lower boundary chain block
`ifndef BSCAN_MAP_SVH
`define BSCAN_MAP_SVH

// -----------------------------------------------------------------
// register word indices (byte address = index * 4)
// -----------------------------------------------------------------
`define CSR_IDX        6'h00
`define IRQ_ST_IDX     6'h01
`define IRQ_MASK_IDX   6'h02

// -----------------------------------------------------------------
// mcu_control_status fields
// -----------------------------------------------------------------
`define CSR_POR_BIT    0
`define CSR_EXT_BIT    1
`define CSR_BOD_BIT    2
`define CSR_WDT_BIT    3
`define CSR_TEST_RESET_FLAG_BIT   4
`define CSR_DIS_BIT    7
`define FLAGS_RESET    5'h01

// -----------------------------------------------------------------
// interrupt status / mask fields
// -----------------------------------------------------------------
`define IRQ_TRST_BIT   0
`define IRQ_DIS_BIT    1
`define IRQ_CAP_BIT    2
`define IRQ_UPD_BIT    3

// -----------------------------------------------------------------
// chain layout
// -----------------------------------------------------------------
`define CHAIN_LEN      82
`define NUM_PINS       23
`define CH_RST_LVL     72
`define CH_RST_HV      71
`define CH_OSCEN_HI    70
`define CH_OSCEN_LO    67
`define CH_OSCOBS_HI   66
`define CH_OSCOBS_LO   63
`define CH_TWI_EN      62
`define CH_TIMER_OSC_CELL        25
`define CH_TIMER_OSC_CELL_EN     24
`define SEG_A_PINS     8
`define SEG_CD_PINS    12
`define SEG_CD_BASE    26
`define SEG_B_BASE     73

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TW_CYCLES      3'h4

`endif

/* File: bscan_pkg.sv */
// types shared by the lower boundary chain block
package bscan_pkg;
  `include "bscan_map.svh"

  typedef struct packed {
    logic [`CHAIN_LEN-1:0] chain;
    logic [`CHAIN_LEN-1:0] upd;
    logic                  tck_q;
    logic                  tdo;
    logic                  dis;
    logic [4:0]            flags;
    logic [2:0]            tw_cnt;
    logic                  tw_val;
    logic [3:0]            irq_st;
    logic [3:0]            irq_mask;
    logic                  irq;
    logic                  dp_wr;
    logic [5:0]            dp_idx;
    logic [31:0]           rdata;
    logic                  hready;
    logic                  hresp;
    logic                  port_en;
    logic [3:0]            osc_en;
    logic                  twi_en;
    logic                  timer_osc_cell_en;
  } top_state_t;

  typedef struct packed {
    logic val;
    logic oe_n;
    logic pull;
  } pin_state_t;
endpackage : bscan_pkg

/* File: bscan_sync.sv */
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module bscan_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule : bscan_sync
`default_nettype wire

/* File: bscan_pin_cell.sv */
// boundary cell of one port pin: functional or test drive of value, direction, pull-up
`timescale 1ns/1ps
`default_nettype none
module bscan_pin_cell
  import bscan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       extest,
  input  wire logic [2:0] upd,
  input  wire logic       core_val,
  input  wire logic       core_dir,
  input  wire logic       core_pull,
  output logic            pin_out,
  output logic            pin_oe_n,
  output logic            pin_pull
);
  pin_state_t s_r;
  pin_state_t s_nxt;

  // upd[2] value cell, upd[1] direction cell, upd[0] pull-up cell
  always_comb begin
    s_nxt = s_r;
    if (extest) begin
      s_nxt.val  = upd[2];
      s_nxt.oe_n = ~upd[1];
      s_nxt.pull = upd[0];
    end else begin
      s_nxt.val  = core_val;
      s_nxt.oe_n = ~core_dir;
      s_nxt.pull = core_pull;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r      <= '0;
      s_r.oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_out  = s_r.val;
  assign pin_oe_n = s_r.oe_n;
  assign pin_pull = s_r.pull;

  pin_ff_a: assert property (@(posedge clk) disable iff (reset)
    extest |=> (pin_out == $past(upd[2])) && (pin_oe_n == !$past(upd[1]))
               && (pin_pull == $past(upd[0])))
    else $error("pin cell does not follow its update cells");
endmodule : bscan_pin_cell
`default_nettype wire

/* File: tap_model.sv */
// behavioural boundary-scan tester on the far side of the test access port
`timescale 1ns/1ps
`default_nettype none
module tap_model (
  output logic      TCK,
  output logic      TDI,
  output logic      TAP_CAPTURE,
  output logic      TAP_SHIFT,
  output logic      TAP_UPDATE,
  output logic      TAP_EXTEST,
  input  wire logic TDO
);
  initial begin
    TCK = 1'b0;
    TDI = 1'b1;
    TAP_CAPTURE = 1'b0;
    TAP_SHIFT = 1'b0;
    TAP_UPDATE = 1'b0;
    TAP_EXTEST = 1'b0;
  end

  // one 800 ns period; controls move 50 ns after the falling edge
  task automatic tick();
    #350 TCK = 1'b1;
    #400 TCK = 1'b0;
    #50;
  endtask : tick

  // link clock stands low between frames
  task automatic scan(input logic cap, input logic upd, input logic [81:0] din,
                      output logic [81:0] dout);
    #13;
    TAP_EXTEST = 1'b1;
    TAP_CAPTURE = cap;
    if (cap) begin
      tick();
    end
    TAP_CAPTURE = 1'b0;
    TAP_SHIFT = 1'b1;
    for (int i = 0; i < 82; i++) begin
      TDI = din[i];
      #350 TCK = 1'b1;
      #400 dout[i] = TDO;
      TCK = 1'b0;
      #50;
    end
    TAP_SHIFT = 1'b0;
    // released data line shows the inverse of the last bit
    TDI = ~TDI;
    TAP_UPDATE = upd;
    if (upd) begin
      tick();
    end
    TAP_UPDATE = 1'b0;
  endtask : scan
endmodule : tap_model
`default_nettype wire

/* File: bscan_lower_tb.sv */
// self-checking bench of the lower boundary chain block
`timescale 1ns/1ps
`default_nettype none
`include "bscan_map.svh"
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t %s", $time, m); end end
module bscan_lower_tb;
  import bscan_pkg::*;
  logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic TEST_RESET_REQ = 1'b0, TEST_PORT_FUSE = 1'b1, EXT_RST_EVT = 1'b0;
  logic BOD_RST_EVT = 1'b0, WDT_RST_EVT = 1'b0, RESET_PIN_LVL = 1'b0;
  logic RESET_HV_DET = 1'b0, TIMER_OSC_CELL_OBS = 1'b0, CORE_TWI_EN = 1'b0, CORE_TIMER_OSC_CELL_EN = 1'b0;
  logic [3:0] CLK_OBS = 4'h0, CORE_OSC_EN = 4'h0;
  logic [`NUM_PINS-1:0] PIN_IN = '0, CORE_VAL = '0, CORE_DIR = '0, CORE_PULL = '0;
  wire logic HREADY, HREADYOUT, HRESP, TDO, TEST_PORT_EN, IRQ, TWI_EN, TIMER_OSC_CELL_EN;
  wire logic TCK, TDI, TAP_CAPTURE, TAP_SHIFT, TAP_UPDATE, TAP_EXTEST;
  wire logic [31:0] HRDATA;
  wire logic [3:0] OSC_EN;
  wire logic [`NUM_PINS-1:0] PIN_OUT, PIN_OE_N, PIN_PULL;
  logic [31:0] expq[$];
  logic rd_ph = 1'b0;
  logic [81:0] din, cap, out2;
  int bad_count = 0, check_count = 0, cyc = 0, b;

  assign HREADY = HREADYOUT;
  bscan_lower dut_u (.CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .TCK, .TDI, .TAP_CAPTURE, .TAP_SHIFT,
    .TAP_UPDATE, .TAP_EXTEST, .TEST_RESET_REQ, .TEST_PORT_FUSE, .EXT_RST_EVT,
    .BOD_RST_EVT, .WDT_RST_EVT, .RESET_PIN_LVL, .RESET_HV_DET, .CLK_OBS, .TIMER_OSC_CELL_OBS,
    .PIN_IN, .CORE_VAL, .CORE_DIR, .CORE_PULL, .CORE_OSC_EN, .CORE_TWI_EN,
    .CORE_TIMER_OSC_CELL_EN, .PIN_OUT, .PIN_OE_N, .PIN_PULL, .OSC_EN, .TWI_EN, .TIMER_OSC_CELL_EN, .TDO,
    .TEST_PORT_EN, .IRQ);
  tap_model tap_u (.TCK, .TDI, .TAP_CAPTURE, .TAP_SHIFT, .TAP_UPDATE, .TAP_EXTEST, .TDO);

  initial begin
    forever #50 CLK = ~CLK;
  end

  // ------------------------------------------------------------
  // bus master, read monitor, closing
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    HSIZE <= 3'h2;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // read data checked mid data phase, clear of the edge that ends it
  always @(negedge CLK) begin
    if (rd_ph) begin
      `CHK(HRDATA, expq.pop_front(), "read data")
      `CHK({HREADYOUT, HRESP}, 2'h2, "okay response")
    end
  end

  always @(posedge CLK) begin
    rd_ph <= HSEL && HTRANS[1] && HREADY && !HWRITE;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      test_done();
    end
  end

  function automatic int base(input int p);
    if (p < 8) return 3 * p;
    if (p < 20) return 26 + 3 * (p - 8);
    return 73 + 3 * (p - 20);
  endfunction : base

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(70));
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    {PIN_IN, CORE_VAL, CORE_DIR} <= 69'({$urandom, $urandom, $urandom});
    {CORE_PULL, CLK_OBS, CORE_OSC_EN} <= 31'($urandom);
    {RESET_PIN_LVL, RESET_HV_DET, TIMER_OSC_CELL_OBS, CORE_TWI_EN, CORE_TIMER_OSC_CELL_EN} <= 5'($urandom);
    rd(32'h0, 32'h01);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    bus(1'b1, 32'h40, 32'hff);
    rd(32'h40, 32'h0);
    bus(1'b1, 32'h8, 32'hff);
    rd(32'h8, 32'h0f);
    bus(1'b1, 32'h8, 32'h0);
    $display("test registers done");
    din = 82'({$urandom, $urandom, $urandom});
    tap_u.scan(1'b1, 1'b1, din, cap);
    repeat (10) @(posedge CLK);
    for (int p = 0; p < `NUM_PINS; p++) begin
      b = base(p);
      `CHK(cap[b+2], PIN_IN[p], "capture value")
      `CHK(cap[b +: 2], {CORE_DIR[p], CORE_PULL[p]}, "capture drive")
      `CHK(PIN_OUT[p], din[b+2], "pin value")
      `CHK({PIN_OE_N[p], PIN_PULL[p]}, {~din[b+1], din[b]}, "pin dir pull")
    end
    `CHK(cap[72:71], {RESET_PIN_LVL, RESET_HV_DET}, "reset observe")
    `CHK(cap[66:63], CLK_OBS, "clock observe")
    `CHK(cap[25], TIMER_OSC_CELL_OBS, "timer osc observe")
    `CHK(OSC_EN, din[70:67], "clock enables")
    `CHK({TWI_EN, TIMER_OSC_CELL_EN}, {din[62], din[24]}, "twi and timer enables")
    tap_u.scan(1'b0, 1'b0, ~din, out2);
    `CHK(out2, din, "chain length and order")
    $display("test chain done");
    bus(1'b1, 32'h4, 32'hf);
    bus(1'b1, 32'h0, 32'h80);
    repeat (8) @(posedge CLK);
    bus(1'b1, 32'h0, 32'h80);
    rd(32'h0, 32'h00);
    bus(1'b1, 32'h0, 32'h80);
    bus(1'b1, 32'h0, 32'h80);
    rd(32'h0, 32'h80);
    repeat (6) @(posedge CLK);
    `CHK({TEST_PORT_EN, TDO}, 2'h0, "port disabled")
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h0, 32'h0);
    rd(32'h0, 32'h0);
    repeat (6) @(posedge CLK);
    `CHK(TEST_PORT_EN, 1'b1, "port enabled")
    TEST_PORT_FUSE <= 1'b0;
    repeat (6) @(posedge CLK);
    `CHK(TEST_PORT_EN, 1'b0, "fuse not programmed")
    TEST_PORT_FUSE <= 1'b1;
    repeat (6) @(posedge CLK);
    `CHK(TEST_PORT_EN, 1'b1, "fuse programmed again")
    $display("test timed write done");
    TEST_RESET_REQ <= 1'b1;
    @(posedge CLK);
    TEST_RESET_REQ <= 1'b0;
    EXT_RST_EVT <= 1'b1;
    @(posedge CLK);
    EXT_RST_EVT <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(32'h0, 32'h12);
    bus(1'b1, 32'h0, 32'h02);
    rd(32'h0, 32'h02);
    $display("test reset flags done");
    rd(32'h4, 32'h3);
    `CHK(IRQ, 1'b0, "masked interrupt")
    bus(1'b1, 32'h8, 32'h1);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b1, "interrupt raised")
    bus(1'b1, 32'h4, 32'h1);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b0, "interrupt cleared")
    rd(32'h4, 32'h2);
    repeat (2) @(posedge CLK);
    $display("test interrupt done");
    test_done();
  end
endmodule : bscan_lower_tb
`default_nettype wire
